// ===== verilog/mbf_regs.sv
// top: mic-bias and negative-input fault latches with threshold registers
`timescale 1ns/1ns
module mbf_regs (
   input  wire logic                     mclk,
   input  wire logic                     rst_n,
   input  wire logic [7:0]               reg_addr,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   input  wire logic [7:0]               reg_wdata,
   output logic      [7:0]               reg_rdata,
   output logic                          reg_ack,
   input  wire logic [3:0]               neg_ov_pin,
   input  wire logic                     bias_ov_pin,
   input  wire logic [mbf_pkg::UA_W-1:0] bias_load_ua,
   input  wire logic                     bias_meas_valid,
   output logic                          fault_irq_req
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]               rdata;
      logic                     ack;
      logic                     irq;
      logic [4:0]               mask;
      logic [7:0]               high_current_limit_code;
      logic [7:0]               low_current_limit_code;
      logic [mbf_pkg::UA_W-1:0] high_limit_ua;
      logic [mbf_pkg::UA_W-1:0] low_limit_ua;
   } mbf_regs_state_t;

   mbf_regs_state_t st_r;
   mbf_regs_state_t st_nxt;

   logic [3:0] neg_ov_sync;
   logic       bias_ov_sync;

   mbf_latch_if #(.W(4)) neg_lt ();
   mbf_latch_if #(.W(3)) bias_lt ();

   // ------------------------------------------------------------
   // comparator inputs cross into the clock domain
   // ------------------------------------------------------------
   mbf_sync2 #(
      .W (4)
   ) u_sync_neg (
      .mclk  (mclk),
      .rst_n (rst_n),
      .d     (neg_ov_pin),
      .q     (neg_ov_sync)
   );

   mbf_sync2 #(
      .W (1)
   ) u_sync_bias (
      .mclk  (mclk),
      .rst_n (rst_n),
      .d     (bias_ov_pin),
      .q     (bias_ov_sync)
   );

   // ------------------------------------------------------------
   // sticky fault flags
   // ------------------------------------------------------------
   mbf_sticky_latch #(
      .W (4)
   ) u_neg_latch (
      .mclk  (mclk),
      .rst_n (rst_n),
      .lt    (neg_lt)
   );

   mbf_sticky_latch #(
      .W (3)
   ) u_bias_latch (
      .mclk  (mclk),
      .rst_n (rst_n),
      .lt    (bias_lt)
   );

   // ------------------------------------------------------------
   // limit code to microamps
   // ------------------------------------------------------------
   function automatic logic [mbf_pkg::UA_W-1:0] code_to_ua(input logic [7:0] code);
      logic [7:0]  steps;
      logic [17:0] prod;
      steps = 8'h00;
      prod  = 18'h00000;
      if (code >= mbf_pkg::LIMIT_CODE_BASE) begin
         steps = code - mbf_pkg::LIMIT_CODE_BASE;
      end
      prod = {10'h000, steps} * {8'h00, mbf_pkg::LIMIT_STEP_UA};
      return prod[mbf_pkg::UA_W-1:0];
   endfunction

   // ------------------------------------------------------------
   // fault detection and clear-on-read
   // ------------------------------------------------------------
   always_comb begin
      neg_lt.set  = neg_ov_sync;
      neg_lt.clr  = 4'h0;
      bias_lt.set = 3'h0;
      bias_lt.clr = 3'h0;

      for (int ch = 0; ch < mbf_pkg::NUM_CHAN; ch++) begin
         if (reg_rd && reg_addr == mbf_pkg::ADDR_CHAN1_FAULT_LATCH + 8'(ch)) begin
            neg_lt.clr[3 - ch] = 1'b1;
         end
      end

      if (bias_meas_valid) begin
         bias_lt.set[mbf_pkg::BIAS_POS_HIGH_CUR] = bias_load_ua > st_r.high_limit_ua;
         bias_lt.set[mbf_pkg::BIAS_POS_LOW_CUR]  = bias_load_ua < st_r.low_limit_ua;
      end
      bias_lt.set[mbf_pkg::BIAS_POS_OV] = bias_ov_sync;

      if (reg_rd && reg_addr == mbf_pkg::ADDR_BIAS_FAULT_LATCH) begin
         bias_lt.clr = 3'h7;
      end
   end

   // ------------------------------------------------------------
   // register access and interrupt request
   // ------------------------------------------------------------
   always_comb begin
      st_nxt     = st_r;
      st_nxt.ack = reg_rd | reg_wr;

      // writes; read-only and unmapped addresses ignore them
      if (reg_wr) begin
         case (reg_addr)
            mbf_pkg::ADDR_FAULT_INTERRUPT_MASK: begin
               st_nxt.mask = reg_wdata[7:mbf_pkg::MASK_LSB];
            end
            mbf_pkg::ADDR_BIAS_HIGH_CURRENT_THR: begin
               st_nxt.high_current_limit_code = reg_wdata;
            end
            mbf_pkg::ADDR_BIAS_LOW_CURRENT_THR: begin
               st_nxt.low_current_limit_code = reg_wdata;
            end
            default: begin
               st_nxt.mask = st_r.mask;
            end
         endcase
      end

      st_nxt.high_limit_ua = code_to_ua(st_r.high_current_limit_code);
      st_nxt.low_limit_ua  = code_to_ua(st_r.low_current_limit_code);

      // reads return the value before any clear in the same cycle
      st_nxt.rdata = mbf_pkg::RST_BYTE;
      if (reg_rd) begin
         case (reg_addr)
            mbf_pkg::ADDR_FAULT_INTERRUPT_MASK: begin
               st_nxt.rdata = {st_r.mask, 3'h0};
            end
            mbf_pkg::ADDR_INPUT_NEG_OVERVOLT: begin
               st_nxt.rdata = {neg_lt.q, 4'h0};
            end
            mbf_pkg::ADDR_BIAS_FAULT_LATCH: begin
               st_nxt.rdata = {bias_lt.q, 5'h00};
            end
            mbf_pkg::ADDR_BIAS_HIGH_CURRENT_THR: begin
               st_nxt.rdata = st_r.high_current_limit_code;
            end
            mbf_pkg::ADDR_BIAS_LOW_CURRENT_THR: begin
               st_nxt.rdata = st_r.low_current_limit_code;
            end
            default: begin
               st_nxt.rdata = mbf_pkg::RST_BYTE;
            end
         endcase
      end

      st_nxt.irq = (|neg_lt.q & ~st_r.mask[mbf_pkg::MASK_POS_NEG_OV])
                 | (bias_lt.q[mbf_pkg::BIAS_POS_HIGH_CUR]
                    & ~st_r.mask[mbf_pkg::MASK_POS_HIGH_CUR])
                 | (bias_lt.q[mbf_pkg::BIAS_POS_LOW_CUR]
                    & ~st_r.mask[mbf_pkg::MASK_POS_LOW_CUR])
                 | (bias_lt.q[mbf_pkg::BIAS_POS_OV]
                    & ~st_r.mask[mbf_pkg::MASK_POS_BIAS_OV]);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r                         <= '0;
         st_r.mask                    <= mbf_pkg::RST_FAULT_MASK;
         st_r.high_current_limit_code <= mbf_pkg::RST_HIGH_CURRENT_LIMIT;
         st_r.low_current_limit_code  <= mbf_pkg::RST_LOW_CURRENT_LIMIT;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata     = st_r.rdata;
   assign reg_ack       = st_r.ack;
   assign fault_irq_req = st_r.irq;

endmodule

// ===== verilog/mbf_pkg.sv
// package: register map, reset values and current-threshold scaling constants
package mbf_pkg;

   // ------------------------------------------------------------
   // register offsets (page 0)
   // ------------------------------------------------------------
   localparam logic [7:0]  ADDR_FAULT_INTERRUPT_MASK   = 8'h34;
   localparam logic [7:0]  ADDR_INPUT_NEG_OVERVOLT     = 8'h36;
   localparam logic [7:0]  ADDR_BIAS_FAULT_LATCH       = 8'h37;
   localparam logic [7:0]  ADDR_BIAS_HIGH_CURRENT_THR  = 8'h38;
   localparam logic [7:0]  ADDR_BIAS_LOW_CURRENT_THR   = 8'h39;
   localparam logic [7:0]  ADDR_CHAN1_FAULT_LATCH      = 8'h2E;
   localparam int          NUM_CHAN                    = 4;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0]  RST_HIGH_CURRENT_LIMIT      = 8'hBA;
   localparam logic [7:0]  RST_LOW_CURRENT_LIMIT       = 8'h4B;
   localparam logic [4:0]  RST_FAULT_MASK              = 5'h00;
   localparam logic [7:0]  RST_BYTE                    = 8'h00;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int          MASK_LSB                    = 3;
   localparam int          MASK_POS_NEG_OV             = 3;
   localparam int          MASK_POS_HIGH_CUR           = 2;
   localparam int          MASK_POS_LOW_CUR            = 1;
   localparam int          MASK_POS_BIAS_OV            = 0;
   localparam int          BIAS_POS_HIGH_CUR           = 2;
   localparam int          BIAS_POS_LOW_CUR            = 1;
   localparam int          BIAS_POS_OV                 = 0;

   // ------------------------------------------------------------
   // threshold code scaling: 0 mA at the base code, fixed step per code
   // ------------------------------------------------------------
   localparam int          UA_W                        = 17;
   localparam logic [7:0]  LIMIT_CODE_BASE             = 8'h39;
   localparam logic [9:0]  LIMIT_STEP_UA               = 10'h21C;

endpackage

// ===== verilog/mbf_latch_if.sv
// interface: set, clear and state of a group of sticky fault flags
`timescale 1ns/1ns
interface mbf_latch_if #(
   parameter int W = 4
);
   logic [W-1:0] set;
   logic [W-1:0] clr;
   logic [W-1:0] q;

   modport owner (input set, input clr, output q);
   modport user  (output set, output clr, input q);
endinterface

// ===== verilog/mbf_sync2.sv
// two-flop synchroniser for asynchronous fault comparator levels
`timescale 1ns/1ns
module mbf_sync2 #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } mbf_sync_state_t;

   mbf_sync_state_t st_r;
   mbf_sync_state_t st_nxt;

   always_comb begin
      st_nxt        = st_r;
      st_nxt.stage1 = d;
      st_nxt.stage2 = st_r.stage1;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.stage2;

endmodule

// ===== verilog/mbf_sticky_latch.sv
// group of sticky fault flags; a set in the clearing cycle wins
`timescale 1ns/1ns
module mbf_sticky_latch #(
   parameter int W = 4
) (
   input  wire logic mclk,
   input  wire logic rst_n,
   mbf_latch_if.owner lt
);

   typedef struct packed {
      logic [W-1:0] flag;
   } mbf_latch_state_t;

   mbf_latch_state_t st_r;
   mbf_latch_state_t st_nxt;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.flag = (st_r.flag & ~lt.clr) | lt.set;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign lt.q = st_r.flag;

endmodule

// ===== sim/mbf_regs_assertions.sv
// checker: register port and fault latch assertions
`timescale 1ns/1ns
module mbf_regs_chk (
   input wire logic                     mclk,
   input wire logic                     rst_n,
   input wire logic [7:0]               reg_addr,
   input wire logic                     reg_wr,
   input wire logic                     reg_rd,
   input wire logic [7:0]               reg_wdata,
   input wire logic [7:0]               reg_rdata,
   input wire logic                     reg_ack,
   input wire logic [3:0]               neg_ov_pin,
   input wire logic                     bias_ov_pin,
   input wire logic [mbf_pkg::UA_W-1:0] bias_load_ua,
   input wire logic                     bias_meas_valid,
   input wire logic                     fault_irq_req
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   chk_ack_follows_req: assert property ((reg_rd || reg_wr) |=> reg_ack)
      else $error("ack missing after request");
   chk_ack_has_cause: assert property (reg_ack |-> $past(reg_rd || reg_wr))
      else $error("ack without request");
   chk_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero when idle");
   chk_neg_rsvd_zero: assert property (
      $past(reg_rd) && $past(reg_addr) == 8'h36 |-> reg_rdata[3:0] == 4'h0)
      else $error("input latch reserved bits set");
   chk_bias_rsvd_zero: assert property (
      $past(reg_rd) && $past(reg_addr) == 8'h37 |-> reg_rdata[4:0] == 5'h00)
      else $error("bias latch reserved bits set");
   chk_chan1_ov_seen: assert property (
      neg_ov_pin[3] [*4] ##1 (reg_rd && reg_addr == 8'h36) |=> reg_rdata[7])
      else $error("channel 1 over-voltage not latched");
   chk_chan4_ov_seen: assert property (
      neg_ov_pin[0] [*4] ##1 (reg_rd && reg_addr == 8'h36) |=> reg_rdata[4])
      else $error("channel 4 over-voltage not latched");
   chk_bias_ov_seen: assert property (
      bias_ov_pin [*4] ##1 (reg_rd && reg_addr == 8'h37) |=> reg_rdata[5])
      else $error("bias over-voltage not latched");
endmodule
bind mbf_regs mbf_regs_chk i_chk (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .reg_ack(reg_ack), .neg_ov_pin(neg_ov_pin), .bias_ov_pin(bias_ov_pin),
   .bias_load_ua(bias_load_ua), .bias_meas_valid(bias_meas_valid),
   .fault_irq_req(fault_irq_req));

// ===== sim/tb_top.sv
// testbench: directed register and fault latch scenarios
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("FAIL %s exp %0h got %0h", n, e, g); end end
module tb_top;
   localparam int            W = mbf_pkg::UA_W;
   logic                     mclk = 1'b0;
   logic                     rst_n = 1'b0;
   logic [7:0]               reg_addr = 8'h00;
   logic                     reg_wr = 1'b0;
   logic                     reg_rd = 1'b0;
   logic [7:0]               reg_wdata = 8'h00;
   logic [7:0]               reg_rdata;
   logic                     reg_ack;
   logic [4:0]               pins = 5'h00;
   logic [W-1:0]             load_ua = '0;
   logic                     meas = 1'b0;
   logic                     irq;
   int                       fail_count = 0;
   int                       total_checks = 0;
   always #5 mclk = ~mclk;
   mbf_regs i_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .neg_ov_pin(pins[4:1]), .bias_ov_pin(pins[0]), .bias_load_ua(load_ua),
      .bias_meas_valid(meas), .fault_irq_req(irq));
   // ------------------------------------------------------------
   // bus and pin tasks
   // ------------------------------------------------------------
   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge mclk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge mclk);
      reg_rd = 1'b0;
      `CHK("ack", 1'b1, reg_ack)
      `CHK("rdata", e, reg_rdata)
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      @(negedge mclk);
      reg_wr = 1'b0;
      `CHK("ack", 1'b1, reg_ack)
   endtask
   task automatic raise(input logic [4:0] p);
      pins = p;
      idle(5);
   endtask
   task automatic drop();
      pins = 5'h00;
      idle(3);
   endtask
   function automatic int lim(input logic [7:0] c);
      return (int'(c) - 57) * 540;
   endfunction
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      rd(8'h36, 8'h00);
      rd(8'h37, 8'h00);
      rd(8'h38, 8'hBA);
      rd(8'h39, 8'h4B);
      rd(8'h34, 8'h00);
   endtask
   task automatic t_access();
      wr(8'h38, 8'hF2);
      rd(8'h38, 8'hF2);
      wr(8'h39, 8'h39);
      rd(8'h39, 8'h39);
      wr(8'h36, 8'h00);
      rd(8'h36, 8'h00);
      wr(8'h37, 8'h00);
      rd(8'h37, 8'h00);
      wr(8'h3A, 8'h5A);
      rd(8'h3A, 8'h00);
      wr(8'h34, 8'hFF);
      rd(8'h34, 8'hF8);
      wr(8'h34, 8'h00);
   endtask
   task automatic t_neg();
      logic [7:0] e;
      for (int k = 0; k < 4; k++) begin
         e = 8'h80 >> k;
         raise(5'h10 >> k);
         rd(8'h36, e);
         drop();
         rd(8'h36, e);
         rd(8'(8'h2E + ((k + 1) % 4)), 8'h00);
         rd(8'h36, e);
         rd(8'(8'h2E + k), 8'h00);
         rd(8'h36, 8'h00);
      end
   endtask
   task automatic bias_case(input logic [7:0] hi, input logic [7:0] lo, input int ua,
                            input logic [7:0] e);
      wr(8'h38, hi);
      wr(8'h39, lo);
      idle(1);
      load_ua = W'(ua);
      meas = 1'b1;
      idle(1);
      meas = 1'b0;
      idle(1);
      rd(8'h37, e);
      rd(8'h37, 8'h00);
   endtask
   task automatic t_bias();
      bias_case(8'hBA, 8'h4B, lim(8'hBA) + 1, 8'h80);
      bias_case(8'hBA, 8'h4B, lim(8'hBA), 8'h00);
      bias_case(8'hBA, 8'h4B, lim(8'h4B) - 1, 8'h40);
      bias_case(8'hBA, 8'h4B, lim(8'h4B), 8'h00);
      bias_case(8'h39, 8'h39, 1, 8'h80);
      bias_case(8'h3A, 8'h39, lim(8'h3A), 8'h00);
      bias_case(8'h3B, 8'h39, lim(8'h3B) + 1, 8'h80);
      bias_case(8'hF2, 8'hF2, lim(8'hF2) - 1, 8'h40);
      raise(5'h01);
      rd(8'h37, 8'h20);
      drop();
      rd(8'h37, 8'h20);
      rd(8'h37, 8'h00);
   endtask
   task automatic irq_case(input logic [7:0] m, input logic [4:0] p, input logic [7:0] ca,
                           input logic [7:0] ce);
      wr(8'h34, m);
      raise(p);
      drop();
      `CHK("irq", 1'b0, irq)
      wr(8'h34, 8'h00);
      idle(1);
      `CHK("irq", 1'b1, irq)
      rd(ca, ce);
      idle(1);
      `CHK("irq", 1'b0, irq)
   endtask
   task automatic t_cur_mask();
      wr(8'h34, 8'h10);
      load_ua = '0;
      meas = 1'b1;
      idle(1);
      meas = 1'b0;
      idle(2);
      `CHK("irq", 1'b0, irq)
      wr(8'h34, 8'h20);
      idle(1);
      `CHK("irq", 1'b1, irq)
      rd(8'h37, 8'h40);
      load_ua = W'(lim(8'hF2) + 1);
      meas = 1'b1;
      idle(1);
      meas = 1'b0;
      idle(2);
      `CHK("irq", 1'b0, irq)
      wr(8'h34, 8'h00);
      idle(1);
      `CHK("irq", 1'b1, irq)
      rd(8'h37, 8'h80);
      idle(1);
      `CHK("irq", 1'b0, irq)
   endtask
   task automatic conclude();
      $display("checks %0d fails %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      idle(10);
      rst_n = 1'b1;
      t_reset();
      t_access();
      t_neg();
      t_bias();
      irq_case(8'h40, 5'h10, 8'h2E, 8'h00);
      irq_case(8'h08, 5'h01, 8'h37, 8'h20);
      t_cur_mask();
      conclude();
   end
   initial begin
      #100000;
      fail_count++;
      conclude();
   end
endmodule
